// *** spfc_pkg.sv ***
/*
 self-programming flash control package: register layout, lock byte layout,
 control patterns and timing constants.
 assumes a core that writes the control register over a simple write strobe.
*/
// Functional notes
// - page erase/write to readable section sets busy bit 6; section refused.
// - busy clears on re-enable after completion or when buffer load starts.
// - signature select plus enable: load within three cycles returns signature.
// - store within four cycles after signature arm has no effect.
// - re-enable plus store within four cycles re-enables; not while busy.
// - re-enable written during buffer load aborts load and discards data.
// - lock set plus store within four cycles programs lock bits from R0.
// - lock set select clears on completion or four-cycle timeout.
// - load within three cycles after lock arm returns lock or fuse by Z0.
// - page write plus store writes buffer to page at upper Z; auto-clears.
// - page erase plus store erases page at upper Z; auto-clears.
// - erase or write to halting section stalls the core throughout.
// - enable alone: store puts R1:R0 into buffer word at Z, Z0 ignored.
// - enable arms four cycles, clears after store, held during erase/write.
// - writes with other than five permitted low patterns update bit 7 only.
// - lock bits only go from one to zero except by chip erase.
// - without boot section, buffer and page stores need self-programming fuse programmed.
// - memory lock modes restrict external programming and verification.
// - application lock pair modes restrict store writes and boot reads.
// - boot lock pair modes restrict store writes and application reads.
// - lock byte: boot locks at 5..2, memory locks at 1..0, reset ones.
// - ready interrupt requested while enabled, global on and enable clear.
package spfc_pkg;
   localparam logic [7:0] SPFC_CSR_RESET   = 8'h00;
   localparam int         SPFC_BIT_IE      = 7;
   localparam int         SPFC_BIT_BUSY    = 6;
   localparam int         SPFC_BIT_SIG     = 5;
   localparam int         SPFC_BIT_REEN    = 4;
   localparam int         SPFC_BIT_LOCK    = 3;
   localparam int         SPFC_BIT_PGWR    = 2;
   localparam int         SPFC_BIT_PGER    = 1;
   localparam int         SPFC_BIT_EN      = 0;
   localparam logic [4:0] SPFC_PAT_REEN    = 5'h11;
   localparam logic [4:0] SPFC_PAT_LOCK    = 5'h09;
   localparam logic [4:0] SPFC_PAT_PGWR    = 5'h05;
   localparam logic [4:0] SPFC_PAT_PGER    = 5'h03;
   localparam logic [4:0] SPFC_PAT_FILL    = 5'h01;
   localparam logic [5:0] SPFC_PAT_SIG     = 6'h21; // sig uses bit 5
   localparam logic [7:0] SPFC_LOCK_RESET  = 8'hff;
   localparam int         SPFC_STORE_WIN   = 4;
   localparam int         SPFC_LOAD_WIN    = 3;
   localparam logic [2:0] SPFC_STORE_WIN_C = 3'h4;
   localparam logic [2:0] SPFC_LOAD_WIN_C  = 3'h3;
   typedef enum logic [1:0] {SPFC_IDLE, SPFC_ARMED, SPFC_BUSY} spfc_state_t;
endpackage : spfc_pkg

// *** spfc_ctrl.sv ***
/*
 self-programming flash control: control/status register, arming window,
 dispatch of store/load instructions to flash array, buffer and lock bits.
 assumes the core presents one-cycle instruction strobes and the flash array
 answers with a done pulse; chip erase arrives as a pulse from programming.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_ctrl #(
   parameter int PAGE_BITS = 7,
   parameter int WORD_BITS = 6,
   parameter bit HAS_BOOT  = 1'b1
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 csr_we,
   input  wire logic [7:0]           csr_wdata,
   output logic      [7:0]           csr_rdata,
   input  wire logic                 store_program_instr,
   input  wire logic                 load_program_instr,
   input  wire logic [15:0]          z_ptr,
   input  wire logic [7:0]           r0_data,
   input  wire logic [7:0]           r1_data,
   input  wire logic                 exec_in_boot,
   input  wire logic                 vectors_in_boot,
   input  wire logic                 global_irq_en,
   input  wire logic                 self_prog_fuse,
   input  wire logic [PAGE_BITS-1:0] rww_limit_page,
   input  wire logic [PAGE_BITS-1:0] boot_start_page,
   input  wire logic [7:0]           fuse_low,
   input  wire logic [7:0]           fuse_high,
   input  wire logic [7:0]           sig_byte,
   input  wire logic                 chip_erase,
   input  wire logic                 flash_done,
   output logic                      load_valid,
   output logic      [7:0]           load_data,
   output logic                      buf_we,
   output logic      [WORD_BITS-1:0] buf_addr,
   output logic      [15:0]          buf_wdata,
   output logic                      buf_clear,
   output logic                      flash_erase,
   output logic                      flash_write,
   output logic      [PAGE_BITS-1:0] flash_page,
   output logic                      core_stall,
   output logic                      rww_access_ok,
   output logic                      store_ready_irq,
   output logic                      irq_block,
   output logic                      ext_prog_block,
   output logic                      ext_verify_block,
   output logic                      fuse_locked,
   output logic                      boot_lock_locked,
   output logic      [7:0]           lock_bits
);
   spfc_pkg::spfc_state_t state_reg, state_next;
   logic [7:0]           csr_reg;
   logic [2:0]           win_reg;
   logic                 halt_reg;
   logic                 fill_reg;
   logic [7:0]           lock_reg;
   logic [7:0]           ld_reg;
   logic                 ldv_reg;
   logic [15:0]          bw_reg;
   logic [WORD_BITS-1:0] ba_reg;
   logic                 bwe_reg;
   logic                 er_reg, wr_reg;
   logic [PAGE_BITS-1:0] pg_reg;

   // pattern decode of a control write
   wire [4:0] wr_low   = csr_wdata[4:0];
   wire       pat_ok   = (wr_low == spfc_pkg::SPFC_PAT_REEN) ||
                         (wr_low == spfc_pkg::SPFC_PAT_LOCK) ||
                         (wr_low == spfc_pkg::SPFC_PAT_PGWR) ||
                         (wr_low == spfc_pkg::SPFC_PAT_PGER) ||
                         (wr_low == spfc_pkg::SPFC_PAT_FILL);
   wire       sig_arm  = csr_wdata[spfc_pkg::SPFC_BIT_SIG] &&
                         wr_low == spfc_pkg::SPFC_PAT_FILL;
   wire       busy_op  = state_reg == spfc_pkg::SPFC_BUSY;
   wire       arm_wr   = csr_we && (pat_ok || sig_arm) && !busy_op;
   wire       armed    = state_reg == spfc_pkg::SPFC_ARMED;
   wire       in_store = armed && (win_reg < spfc_pkg::SPFC_STORE_WIN_C);
   wire       in_load  = armed && (win_reg < spfc_pkg::SPFC_LOAD_WIN_C);
   wire       timeout  = armed && (win_reg == spfc_pkg::SPFC_STORE_WIN_C);

   // section decode and lock-mode restrictions
   wire [PAGE_BITS-1:0] z_page = z_ptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
   wire tgt_boot  = HAS_BOOT && (z_page >= boot_start_page);
   wire tgt_rww   = z_page < rww_limit_page;
   wire [1:0] app_lk  = lock_reg[3:2];
   wire [1:0] boot_lk = lock_reg[5:4];
   wire app_wr_blk  = HAS_BOOT && !app_lk[0];
   wire boot_wr_blk = HAS_BOOT && !boot_lk[0];
   wire app_rd_blk  = HAS_BOOT && !app_lk[1] && exec_in_boot;
   wire boot_rd_blk = HAS_BOOT && !boot_lk[1] && !exec_in_boot;
   wire fuse_ok     = HAS_BOOT || !self_prog_fuse;
   wire wr_allowed  = fuse_ok &&
                      !(tgt_boot ? boot_wr_blk : app_wr_blk);
   wire store_go    = store_program_instr && in_store;
   wire [4:0] c_low = csr_reg[4:0];
   wire sig_mode    = csr_reg[spfc_pkg::SPFC_BIT_SIG];
   wire do_fill = store_go && !sig_mode &&
                  c_low == spfc_pkg::SPFC_PAT_FILL && fuse_ok;
   wire do_page = store_go && !sig_mode && wr_allowed &&
                  (c_low == spfc_pkg::SPFC_PAT_PGWR ||
                   c_low == spfc_pkg::SPFC_PAT_PGER);
   wire do_lock = store_go && c_low == spfc_pkg::SPFC_PAT_LOCK;
   wire do_reen = store_go && c_low == spfc_pkg::SPFC_PAT_REEN;
   wire sig_nop = store_go && sig_mode;
   wire reen_abort = csr_we &&
                     csr_wdata[spfc_pkg::SPFC_BIT_REEN] && fill_reg;

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         spfc_pkg::SPFC_IDLE:  if (arm_wr) begin
            state_next = spfc_pkg::SPFC_ARMED;
         end
         spfc_pkg::SPFC_ARMED: if (do_page) begin
            state_next = spfc_pkg::SPFC_BUSY;
         end else if ((store_go || timeout) && !arm_wr) begin
            state_next = spfc_pkg::SPFC_IDLE;
         end
         spfc_pkg::SPFC_BUSY:  if (flash_done) begin
            state_next = spfc_pkg::SPFC_IDLE;
         end
         default: state_next = spfc_pkg::SPFC_IDLE;
      endcase
   end

   // state, window counter and control bits
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg <= spfc_pkg::SPFC_IDLE;
         win_reg   <= 3'h0;
         csr_reg   <= spfc_pkg::SPFC_CSR_RESET;
         halt_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         win_reg   <= arm_wr ? 3'h0 : (armed ? win_reg + 3'h1 : 3'h0);
         if (csr_we) begin
            csr_reg[spfc_pkg::SPFC_BIT_IE] <= csr_wdata[spfc_pkg::SPFC_BIT_IE];
         end
         if (arm_wr) begin
            csr_reg[5:0] <= csr_wdata[5:0];
         end else if (state_next == spfc_pkg::SPFC_IDLE && !arm_wr &&
                      state_reg != spfc_pkg::SPFC_IDLE) begin
            csr_reg[5:0] <= 6'h00;
         end
         if (do_page && tgt_rww) begin
            csr_reg[spfc_pkg::SPFC_BIT_BUSY] <= 1'b1;
         end else if (do_reen || do_fill) begin
            csr_reg[spfc_pkg::SPFC_BIT_BUSY] <= 1'b0;
         end
         if (do_page) begin
            halt_reg <= !tgt_rww;
         end else if (flash_done) begin
            halt_reg <= 1'b0;
         end
      end
   end

   // buffer fill tracking, lock bits and flash strobes
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fill_reg <= 1'b0;
         lock_reg <= spfc_pkg::SPFC_LOCK_RESET;
         bwe_reg  <= 1'b0;
         ba_reg   <= '0;
         bw_reg   <= 16'h0000;
         er_reg   <= 1'b0;
         wr_reg   <= 1'b0;
         pg_reg   <= '0;
         ldv_reg  <= 1'b0;
         ld_reg   <= 8'h00;
      end else begin
         fill_reg <= reen_abort || do_page ? 1'b0 : (do_fill | fill_reg);
         if (chip_erase) begin
            lock_reg <= spfc_pkg::SPFC_LOCK_RESET;
         end else if (do_lock) begin
            lock_reg <= lock_reg & {2'b11, r0_data[5:0]};
         end
         bwe_reg <= do_fill;
         if (do_fill) begin
            ba_reg <= z_ptr[WORD_BITS:1];
            bw_reg <= {r1_data, r0_data};
         end
         er_reg <= do_page && c_low == spfc_pkg::SPFC_PAT_PGER;
         wr_reg <= do_page && c_low == spfc_pkg::SPFC_PAT_PGWR;
         if (do_page) begin
            pg_reg <= z_page;
         end
         ldv_reg <= load_program_instr;
         if (load_program_instr) begin
            if (in_load && sig_mode) begin
               ld_reg <= sig_byte;
            end else if (in_load && c_low == spfc_pkg::SPFC_PAT_LOCK) begin
               ld_reg <= z_ptr[0] ? fuse_high : lock_reg;
            end else if ((tgt_boot && boot_rd_blk) ||
                         (!tgt_boot && app_rd_blk)) begin
               ld_reg <= 8'hff;
            end else begin
               ld_reg <= fuse_low;
            end
         end
      end
   end

   // outputs
   assign csr_rdata = {csr_reg[7:6], csr_reg[5:1],
                       csr_reg[0] | busy_op};
   assign load_valid       = ldv_reg;
   assign load_data        = ld_reg;
   assign buf_we           = bwe_reg;
   assign buf_addr         = ba_reg;
   assign buf_wdata        = bw_reg;
   assign buf_clear        = reen_abort;
   assign flash_erase      = er_reg;
   assign flash_write      = wr_reg;
   assign flash_page       = pg_reg;
   assign core_stall       = halt_reg;
   assign rww_access_ok    = !csr_reg[spfc_pkg::SPFC_BIT_BUSY];
   assign store_ready_irq  = csr_reg[7] && global_irq_en &&
                             !csr_rdata[0];
   assign irq_block = HAS_BOOT && (exec_in_boot ?
                      (!vectors_in_boot && !boot_lk[1]) :
                      (vectors_in_boot && !app_lk[1]));
   assign ext_prog_block   = !lock_reg[0];
   assign fuse_locked      = !lock_reg[0];
   assign ext_verify_block = !lock_reg[0] && !lock_reg[1];
   assign boot_lock_locked = !lock_reg[0] && !lock_reg[1];
   assign lock_bits        = lock_reg;

   // store commands are honoured only inside the four-cycle window
   AST_STORE_WIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (flash_erase || flash_write) |-> $past(in_store))
      else $error("page operation started outside window");
   AST_TIMEOUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timeout && !store_program_instr |=>
      csr_reg[4:0] == 5'h00 || $past(arm_wr))
      else $error("selects not cleared on timeout");
   AST_BUSY_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      do_page && tgt_rww |=> !rww_access_ok)
      else $error("busy not set on readable page operation");
   AST_STALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      core_stall && !flash_done |=> core_stall)
      else $error("stall dropped before completion");
   AST_EN_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busy_op |-> csr_reg[spfc_pkg::SPFC_BIT_EN])
      else $error("enable low during page operation");
   AST_LOCK_MONO: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !$past(chip_erase) |-> (lock_reg & ~$past(lock_reg)) == 8'h00)
      else $error("lock bit returned to one");
   AST_SIG_NOP: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sig_nop |=> !flash_erase && !flash_write && !buf_we)
      else $error("store acted during signature arm");
   AST_BAD_PAT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      csr_we && !pat_ok && !sig_arm && !armed && !busy_op |=>
      state_reg == spfc_pkg::SPFC_IDLE)
      else $error("illegal pattern armed");
endmodule : spfc_ctrl
`default_nettype wire

// *** spfc_flash_model.sv ***
/*
 flash array stand-in: answers every page erase or page write with a
 one-cycle done pulse after a fixed busy time.
 assumes the erase and write requests are single-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_flash_model #(
   parameter int DONE_DELAY = 6
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic flash_erase,
   input  wire logic flash_write,
   output logic      flash_done
);
   int cnt_reg;
   // busy countdown, done raised on the last count
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_reg    <= 0;
         flash_done <= 1'b0;
      end else begin
         flash_done <= 1'b0;
         if (flash_erase || flash_write) begin
            cnt_reg <= DONE_DELAY;
         end else if (cnt_reg != 0) begin
            cnt_reg    <= cnt_reg - 1;
            flash_done <= (cnt_reg == 1);
         end
      end
   end
endmodule : spfc_flash_model
`default_nettype wire

// *** self_program_flash_control_tb_top.sv ***
/*
 bench for the flash control block: random fills, arming windows, page
 ops, signature and lock access. assumes spfc_ctrl and the flash model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module self_program_flash_control_tb_top;
   logic        clk_sys, rst_n, csr_we, store_program_instr, load_program_instr;
   logic        global_irq_en, chip_erase, flash_done, load_valid, buf_we;
   logic        buf_clear, flash_erase, flash_write, core_stall, rww_access_ok;
   logic        store_ready_irq, irq_block, ext_prog_block, ext_verify_block;
   logic        fuse_locked, boot_lock_locked, exec_in_boot, vectors_in_boot;
   logic [7:0]  csr_wdata, csr_rdata, r0_data, r1_data, fuse_low, fuse_high;
   logic [7:0]  sig_byte, load_data, lock_bits, lk, r0_keep;
   logic [15:0] z_ptr, buf_wdata;
   logic [6:0]  flash_page;
   logic [5:0]  buf_addr;
   int          fail_count, tests_run, seed, cycles;
   spfc_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .csr_we(csr_we),
      .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .z_ptr(z_ptr),
      .store_program_instr(store_program_instr), .r0_data(r0_data),
      .load_program_instr(load_program_instr), .r1_data(r1_data),
      .exec_in_boot(exec_in_boot), .vectors_in_boot(vectors_in_boot),
      .self_prog_fuse(1'b0),
      .global_irq_en(global_irq_en), .rww_limit_page(7'h60),
      .boot_start_page(7'h70), .fuse_low(fuse_low), .fuse_high(fuse_high),
      .sig_byte(sig_byte), .chip_erase(chip_erase), .flash_done(flash_done),
      .load_valid(load_valid), .load_data(load_data), .buf_we(buf_we),
      .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_clear(buf_clear),
      .flash_erase(flash_erase), .flash_write(flash_write),
      .flash_page(flash_page), .core_stall(core_stall),
      .rww_access_ok(rww_access_ok), .store_ready_irq(store_ready_irq),
      .irq_block(irq_block), .ext_prog_block(ext_prog_block),
      .ext_verify_block(ext_verify_block), .fuse_locked(fuse_locked),
      .boot_lock_locked(boot_lock_locked), .lock_bits(lock_bits));
   spfc_flash_model #(.DONE_DELAY(6)) i_flash (.clk_sys(clk_sys),
      .rst_n(rst_n), .flash_erase(flash_erase), .flash_write(flash_write),
      .flash_done(flash_done));
   // lock bits can only fall from one to zero
   function automatic logic [7:0] lock_next(input logic [7:0] o, r);
      return o & {2'b11, r[5:0]};
   endfunction : lock_next
   // interrupt blocking from the lock pairs and where code and vectors sit
   function automatic logic irq_exp(input logic [7:0] l, input logic b, v);
      return b ? (!v && !l[5]) : (v && !l[3]);
   endfunction : irq_exp
   // each request holds one cycle and is released on the next falling edge
   task automatic wr(input logic [7:0] d);
      @(negedge clk_sys);
      csr_we = 1'b1;
      csr_wdata = d;
      @(negedge clk_sys);
      csr_we = 1'b0;
   endtask : wr
   task automatic st(input logic [15:0] z);
      @(negedge clk_sys);
      store_program_instr = 1'b1;
      z_ptr = z;
      r0_data = 8'($random(seed)) | r0_keep;
      r1_data = 8'($random(seed));
      @(negedge clk_sys);
      store_program_instr = 1'b0;
   endtask : st
   task automatic ld(input logic [15:0] z);
      @(negedge clk_sys);
      load_program_instr = 1'b1;
      z_ptr = z;
      @(negedge clk_sys);
      load_program_instr = 1'b0;
   endtask : ld
   task automatic wait_idle;
      for (int i = 0; i < 50 && csr_rdata[0] !== 1'b0; i++) @(negedge clk_sys);
   endtask : wait_idle
   task automatic summarize;
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // free-running clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 3000) begin
         fail_count++;
         summarize();
      end
   end
   // main sequence
   initial begin
      seed = 42815;
      {rst_n, csr_we, store_program_instr, load_program_instr} = '0;
      {chip_erase, csr_wdata, r0_data, r1_data, z_ptr} = '0;
      {exec_in_boot, vectors_in_boot, r0_keep} = '0;
      global_irq_en = 1'b1;
      fuse_low = 8'($random(seed));
      fuse_high = 8'($random(seed));
      sig_byte = 8'($random(seed));
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      `CHK(csr_rdata, 8'h00)
      `CHK(lock_bits, 8'hff)
      // random fills with the store placed across the window edge
      for (int i = 0; i < 16; i++) begin
         wr(8'h01);
         repeat (i % 4) @(negedge clk_sys);
         st(16'($random(seed)));
         `CHK(buf_we, (i % 4) < 3)
         if ((i % 4) < 3) begin
            `CHK(buf_addr, z_ptr[6:1])
            `CHK(buf_wdata, {r1_data, r0_data})
         end
         `CHK(csr_rdata[5:0], 6'h00)
      end
      @(negedge clk_sys);
      csr_we = 1'b1;
      csr_wdata = 8'h11;
      #1 `CHK(buf_clear, 1'b1)
      @(negedge clk_sys);
      csr_we = 1'b0;
      repeat (6) @(negedge clk_sys);
      // patterns outside the permitted set leave the control bits at rest
      for (int p = 0; p < 32; p++) begin
         if (p inside {1, 3, 5, 9, 17}) continue;
         wr(p[7:0]);
         `CHK(csr_rdata[5:0], 6'h00)
      end
      wr(8'h21);
      ld(16'h0000);
      `CHK(load_valid, 1'b1)
      `CHK(load_data, sig_byte)
      wr(8'h21);
      st(16'h0000);
      `CHK({buf_we, flash_erase, flash_write}, 3'h0)
      // erase in the readable section, then re-enable it
      wr(8'h03);
      st(16'h0a00);
      `CHK(flash_erase, 1'b1)
      `CHK(flash_page, 7'h14)
      `CHK(csr_rdata[6], 1'b1)
      `CHK(rww_access_ok, 1'b0)
      `CHK(csr_rdata[0], 1'b1)
      wait_idle();
      `CHK(csr_rdata[6], 1'b1)
      wr(8'h11);
      st(16'h0000);
      `CHK(rww_access_ok, 1'b1)
      `CHK(buf_we, 1'b0)
      // a buffer store also lifts the busy flag
      wr(8'h03);
      st(16'h0a00);
      wait_idle();
      wr(8'h01);
      st(16'h0002);
      `CHK(csr_rdata[6], 1'b0)
      // write to the halting section stalls the core throughout
      wr(8'h05);
      st(16'h3400);
      `CHK(flash_write, 1'b1)
      `CHK(flash_page, 7'h68)
      `CHK(core_stall, 1'b1)
      wait_idle();
      `CHK({core_stall, csr_rdata[2]}, 2'b00)
      wr(8'h80);
      `CHK(store_ready_irq, 1'b1)
      wr(8'h81);
      `CHK(store_ready_irq, 1'b0)
      repeat (6) @(negedge clk_sys);
      // random lock programming, read back of lock byte and fuse byte
      lk = 8'hff;
      for (int i = 0; i < 3; i++) begin
         r0_keep = (i < 2) ? 8'h03 : 8'h00;
         wr(8'h09);
         st(16'h0000);
         lk = lock_next(lk, r0_data);
         `CHK(lock_bits, lk)
         `CHK(ext_prog_block, lk[1:0] != 2'b11)
         `CHK(ext_verify_block, lk[1:0] == 2'b00)
         `CHK(fuse_locked, !lk[0])
         `CHK(boot_lock_locked, lk[1:0] == 2'b00)
         `CHK(csr_rdata[3], 1'b0)
         wr(8'h09);
         ld(16'h0000);
         `CHK(load_data, lk)
         wr(8'h09);
         ld(16'h0001);
         `CHK(load_data, fuse_high)
      end
      // plain reads and interrupt blocking under the programmed locks
      repeat (6) @(negedge clk_sys);
      for (int k = 0; k < 4; k++) begin
         {exec_in_boot, vectors_in_boot} = 2'(k);
         ld(16'h0000);
         `CHK(load_data, (exec_in_boot && !lk[3]) ? 8'hff : fuse_low)
         `CHK(irq_block, irq_exp(lk, exec_in_boot, vectors_in_boot))
         ld(16'h3c00);
         `CHK(load_data, (!exec_in_boot && !lk[5]) ? 8'hff : fuse_low)
      end
      @(negedge clk_sys);
      chip_erase = 1'b1;
      @(negedge clk_sys);
      chip_erase = 1'b0;
      `CHK(lock_bits, 8'hff)
      summarize();
   end
endmodule : self_program_flash_control_tb_top
`default_nettype wire
